// ==== rtl/adv_timer_pkg.sv ====
// Package for the reload, compare and dead-time section of the timer.
// Assumes a 32-bit classic Wishbone register bus on one 20 MHz clock.
package adv_timer_pkg;
    // Register byte offsets
    localparam logic [7:0] reload_offset      = 8'h2c;
    localparam logic [7:0] repetition_offset  = 8'h30;
    localparam logic [7:0] channel1_offset    = 8'h34;
    localparam logic [7:0] channel2_offset    = 8'h38;
    localparam logic [7:0] channel3_offset    = 8'h3c;
    localparam logic [7:0] channel4_offset    = 8'h40;
    localparam logic [7:0] brake_offset       = 8'h44;
    // Own registers: channel control, output control and counter status
    localparam logic [7:0] channel_ctrl_offset = 8'h50;
    localparam logic [7:0] output_ctrl_offset  = 8'h54;
    localparam logic [7:0] status_offset       = 8'h58;

    // Reset values
    localparam logic [15:0] reload_reset     = 16'hffff;
    localparam logic [15:0] zero_reset       = 16'h0000;

    // Brake/dead-time field positions
    localparam int dts_lsb       = 0;
    localparam int lock_lsb      = 8;
    localparam int idle_os_bit   = 10;
    localparam int run_os_bit    = 11;
    localparam int brake_en_bit  = 12;
    localparam int brake_pol_bit = 13;
    localparam int auto_oe_bit   = 14;
    localparam int main_oe_bit   = 15;

    // Channel control register layout, per channel x at 4*x
    localparam int chan_mode_lsb    = 0;  // 0 output, 1 input
    localparam int chan_preload_lsb = 1;  // compare preload enable
    localparam int chan_cmode_lsb   = 2;  // compare mode, 2 bits
    // Output control register layout, per channel x at 4*x
    localparam int out_enable_lsb   = 0;
    localparam int out_pol_lsb      = 1;
    localparam int out_npol_lsb     = 2;
    localparam int out_idle_lsb     = 3;
    // Complementary idle states sit above the channel nibbles
    localparam int out_nidle_lsb    = 16;

    typedef enum logic [1:0] {
        lock_off   = 2'b00,
        lock_one   = 2'b01,
        lock_two   = 2'b10,
        lock_three = 2'b11
    } lock_type;

    typedef enum logic [1:0] {
        out_off      = 2'b00,
        out_deadtime = 2'b01,
        out_active   = 2'b10
    } out_state_type;

    // One Wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_type;

    // Per-channel pin pair
    typedef struct packed {
        logic main_pin;
        logic comp_pin;
    } pin_pair_type;
endpackage

// ==== rtl/adv_timer_reload_compare_deadtime.sv ====
// Reload, repetition, four capture/compare channels, dead time and lock.
// Assumes a classic Wishbone master, one clock, synchronous reset.
//
// Notes on behaviour
// - Reload resets all ones; zero stops counter.
// - Repetition counts down, update at zero, reloads.
// - New repetition value used from next update.
// - Input channel latches counter on capture.
// - Output channel compares value against counter.
// - Preload off: written value applies at once.
// - Preload on: written value applies at update.
// - Channels two to four behave like one.
// - Dead time low ranges: x1 and 2x steps.
// - Dead time high ranges: 8x and 16x steps.
// - Dead-time setting locked at levels one to three.
// - Lock zero leaves everything writable.
// - Level one locks brake and idle bits.
// - Level two adds polarity and off-state bits.
// - Level three adds compare mode and preload.
// - Lock field writable once after reset.
// - Idle off-state bit shapes enable in idle.
// - Run off-state bit shapes enable in run.
// - Off-state zero disables; one drives inactive first.
`timescale 1ns/10ps
module adv_timer_reload_compare_deadtime
    import adv_timer_pkg::*;
#(
    parameter int channels = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire wb_req_type  wb_req_i,      // Wishbone request group
    output logic [31:0]      wb_dat_o,      // Read data
    output logic             wb_ack_o,      // Access acknowledge
    input  wire logic        dt_tick_i,     // Dead-time clock enable pulse
    input  wire logic [3:0]  capture_i,     // Capture event per channel
    output logic [15:0]      counter_o,     // Current counter value
    output logic             update_o,      // Update event pulse
    output pin_pair_type [3:0] pins_o,      // Channel output pairs
    output logic [3:0]       pins_oe_o      // Pin drive enables
);
    // Software-visible registers and internal state
    logic [15:0] reload_limit;          // Auto-reload value
    logic [7:0]  repetition_value;      // Programmed repetition
    logic [7:0]  repetition_left;       // Working repetition count
    logic [15:0] shadow_value [4];      // Values software sees
    logic [15:0] active_value [4];      // Values the comparator uses
    logic [15:0] brake_reg;             // Brake/dead-time register
    logic [15:0] chan_ctrl;             // Mode, preload, compare mode
    logic [31:0] out_ctrl;              // Enables, polarity, idle
    logic        lock_written;          // Lock field already set
    logic [15:0] counter_value;         // Up counter
    logic        update_pulse;          // Update event
    logic        wrap;                  // Counter reached limit

    wire logic     access = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    wire logic     wr     = access && wb_req_i.we;
    wire logic [15:0] wdat = wb_req_i.dat[15:0];
    wire lock_type lock   = lock_type'(brake_reg[lock_lsb +: 2]);

    // Merge 16-bit write data into a register under byte enables
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [3:0]  sel);
        merge16 = old;
        if (sel[0]) merge16[7:0]  = nw[7:0];
        if (sel[1]) merge16[15:8] = nw[15:8];
    endfunction

    // Replace only the bits in mask with new data
    function automatic logic [15:0] guarded(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [15:0] mask);
        guarded = (old & ~mask) | (nw & mask);
    endfunction

    // Dead-time length in ticks from the 8-bit setting
    function automatic logic [10:0] deadtime_ticks(input logic [7:0] s);
        if (!s[7])
            deadtime_ticks = {3'h0, s};
        else if (!s[6])
            deadtime_ticks = {4'h0, 1'b1, s[5:0]} << 1;
        else if (!s[5])
            deadtime_ticks = {5'h0, 1'b1, s[4:0]} << 3;
        else
            deadtime_ticks = {5'h0, 1'b1, s[4:0]} << 4;
    endfunction

    // Acknowledge one cycle after each request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    // Read data mux; unmapped offsets read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (access) begin
            case (wb_req_i.adr)
                reload_offset:       wb_dat_o <= {16'h0, reload_limit};
                repetition_offset:   wb_dat_o <= {24'h0, repetition_value};
                channel1_offset:     wb_dat_o <= {16'h0, shadow_value[0]};
                channel2_offset:     wb_dat_o <= {16'h0, shadow_value[1]};
                channel3_offset:     wb_dat_o <= {16'h0, shadow_value[2]};
                channel4_offset:     wb_dat_o <= {16'h0, shadow_value[3]};
                brake_offset:        wb_dat_o <= {16'h0, brake_reg};
                channel_ctrl_offset: wb_dat_o <= {16'h0, chan_ctrl};
                output_ctrl_offset:  wb_dat_o <= out_ctrl;
                status_offset:       wb_dat_o <= {8'h0, repetition_left,
                                                  counter_value};
                default:             wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Reload and repetition registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_limit     <= reload_reset;
            repetition_value <= 8'h00;
        end else if (wr && wb_req_i.adr == reload_offset) begin
            reload_limit <= merge16(reload_limit, wdat, wb_req_i.sel);
        end else if (wr && wb_req_i.adr == repetition_offset
                     && wb_req_i.sel[0]) begin
            repetition_value <= wdat[7:0];
        end
    end

    // Up counter; a zero limit holds it still
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_value <= 16'h0000;
        end else if (reload_limit == 16'h0000) begin
            counter_value <= counter_value;
        end else if (wrap) begin
            counter_value <= 16'h0000;
        end else begin
            counter_value <= counter_value + 16'h0001;
        end
    end
    assign wrap = (reload_limit != 16'h0000) &&
                  (counter_value >= reload_limit);

    // Repetition counter: update only when it has run down to zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            repetition_left <= 8'h00;
        end else if (wrap) begin
            if (repetition_left == 8'h00)
                repetition_left <= repetition_value;
            else
                repetition_left <= repetition_left - 8'h01;
        end
    end
    assign update_pulse = wrap && (repetition_left == 8'h00);
    assign update_o     = update_pulse;
    assign counter_o    = counter_value;

    // Compare/capture values for all channels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                shadow_value[i] <= zero_reset;
                active_value[i] <= zero_reset;
            end
        end else begin
            for (int i = 0; i < channels; i++) begin
                if (chan_ctrl[4*i + chan_mode_lsb]) begin
                    if (capture_i[i] && out_ctrl[4*i + out_enable_lsb])
                        shadow_value[i] <= counter_value;
                    active_value[i] <= shadow_value[i];
                end else begin
                    if (wr && wb_req_i.adr == channel1_offset
                              + 8'(4*i)) begin
                        shadow_value[i] <= merge16(shadow_value[i], wdat,
                                                   wb_req_i.sel);
                        if (!chan_ctrl[4*i + chan_preload_lsb])
                            active_value[i] <= merge16(shadow_value[i],
                                                       wdat,
                                                       wb_req_i.sel);
                    end
                    if (update_pulse && chan_ctrl[4*i + chan_preload_lsb])
                        active_value[i] <= shadow_value[i];
                end
            end
        end
    end

    // Brake/dead-time register with lock levels
    always_ff @(posedge clk_i) begin
        logic [15:0] mask;
        logic [15:0] nv;
        mask = 16'h0000;
        nv   = 16'h0000;
        if (rst_i) begin
            brake_reg    <= zero_reset;
            lock_written <= 1'b0;
        end else if (wr && wb_req_i.adr == brake_offset) begin
            nv   = merge16(brake_reg, wdat, wb_req_i.sel);
            mask = 16'h8000;
            if (lock == lock_off) begin
                mask = 16'hfcff;
            end else if (lock == lock_one) begin
                mask = 16'h8c00;
            end
            if (!lock_written && wb_req_i.sel[1]) begin
                mask = mask | 16'h0300;
                lock_written <= 1'b1;
            end
            brake_reg <= guarded(brake_reg, nv, mask);
        end
    end

    // Channel control; level three freezes compare mode and preload
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan_ctrl <= zero_reset;
        end else if (wr && wb_req_i.adr == channel_ctrl_offset) begin
            chan_ctrl <= guarded(chan_ctrl,
                                 merge16(chan_ctrl, wdat, wb_req_i.sel),
                                 (lock == lock_three) ? 16'h1111
                                                      : 16'hffff);
        end
    end

    // Output control; levels lock idle and polarity bits
    always_ff @(posedge clk_i) begin
        logic [31:0] mask;
        logic [31:0] nv;
        nv = out_ctrl;
        if (wb_req_i.sel[0]) nv[7:0]   = wb_req_i.dat[7:0];
        if (wb_req_i.sel[1]) nv[15:8]  = wb_req_i.dat[15:8];
        if (wb_req_i.sel[2]) nv[23:16] = wb_req_i.dat[23:16];
        if (wb_req_i.sel[3]) nv[31:24] = wb_req_i.dat[31:24];
        mask = 32'h000f_ffff;
        if (lock != lock_off)
            mask = mask & 32'hfff0_7777;
        if (lock == lock_two || lock == lock_three)
            mask = mask & 32'hfff0_1111;
        if (rst_i) begin
            out_ctrl <= 32'h0000_0000;
        end else if (wr && wb_req_i.adr == output_ctrl_offset) begin
            out_ctrl <= (out_ctrl & ~mask) | (nv & mask);
        end
    end

    // Per-channel output sequencer with dead time
    out_state_type state [4];
    logic [10:0]   dt_count [4];
    logic [3:0]    enable_q;
    logic [3:0]    compare_hit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                state[i]    <= out_off;
                dt_count[i] <= 11'h000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                enable_q[i] <= out_ctrl[4*i + out_enable_lsb];
                case (state[i])
                    out_off: begin
                        // Rising enable: off-state bit picks the path
                        if (out_ctrl[4*i] && !enable_q[i] &&
                            brake_reg[brake_reg[main_oe_bit] ? run_os_bit
                                                 : idle_os_bit]) begin
                            state[i]    <= out_deadtime;
                            dt_count[i] <= deadtime_ticks(brake_reg[7:0]);
                        end
                    end
                    out_deadtime: begin
                        if (!out_ctrl[4*i])
                            state[i] <= out_off;
                        else if (dt_count[i] == 11'h000)
                            state[i] <= out_active;
                        else if (dt_tick_i) begin
                            // Leave on the last tick so the gap is exact
                            dt_count[i] <= dt_count[i] - 11'h001;
                            if (dt_count[i] == 11'h001)
                                state[i] <= out_active;
                        end
                    end
                    out_active: begin
                        if (!out_ctrl[4*i])
                            state[i] <= out_off;
                    end
                    default: state[i] <= out_off;
                endcase
            end
        end
    end

    // Output compare: active while the counter is below the value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            compare_hit[i] = counter_value < active_value[i];
        end
    end

    // Pin drive: inactive in dead time, then idle or compare level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_o    <= '0;
            pins_oe_o <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                pins_oe_o[i] <= (state[i] != out_off);
                if (state[i] == out_deadtime) begin
                    pins_o[i].main_pin <= out_ctrl[4*i + out_pol_lsb];
                    pins_o[i].comp_pin <= out_ctrl[4*i + out_npol_lsb];
                end else if (!brake_reg[main_oe_bit]) begin
                    pins_o[i].main_pin <= out_ctrl[4*i + out_idle_lsb];
                    pins_o[i].comp_pin <= out_ctrl[out_nidle_lsb + i];
                end else begin
                    pins_o[i].main_pin <= compare_hit[i] ^
                                          out_ctrl[4*i + out_pol_lsb];
                    pins_o[i].comp_pin <= !compare_hit[i] ^
                                          out_ctrl[4*i + out_npol_lsb];
                end
            end
        end
    end
endmodule // adv_timer_reload_compare_deadtime

// ==== verif/adv_timer_monitor.sv ====
// Checker for the bus answer, reload counting and update of the timer.
// Assumes one clock and a synchronous active-high reset on the top ports.
`timescale 1ns/10ps
module adv_timer_monitor
    import adv_timer_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire wb_req_type   wb_req_i,
    input  wire logic [31:0]  wb_dat_o,
    input  wire logic         wb_ack_o,
    input  wire logic         dt_tick_i,
    input  wire logic [3:0]   capture_i,
    input  wire logic [15:0]  counter_o,
    input  wire logic         update_o,
    input  wire pin_pair_type [3:0] pins_o,
    input  wire logic [3:0]   pins_oe_o
);
    localparam logic [7:0] hole_offset = 8'h60; // Address with no register
    logic [15:0] reload_seen;                   // Reload limit last written
    logic        ack_last;                      // Answer seen last cycle
    logic        quiet;                         // No bus answer this cycle or last

    // Shadow the reload limit; writes land at the answered edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_seen <= reload_reset;
        end else if (wb_ack_o && wb_req_i.we && wb_req_i.adr == reload_offset)
        begin
            reload_seen <= wb_req_i.dat[15:0];
        end
    end

    // Counting checks skip the cycles around any answer, since a new
    // limit is used one cycle earlier than the shadow sees it
    always_ff @(posedge clk_i) begin
        ack_last <= rst_i ? 1'b0 : wb_ack_o;
    end
    assign quiet = !wb_ack_o && !ack_last;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_answer;
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no answer");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("long answer");
    property p_reset_quiet;
        disable iff (1'b0) rst_i |=> pins_oe_o == 4'h0 && !wb_ack_o &&
            counter_o == 16'h0000;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs busy after reset");
    property p_stopped;
        quiet && reload_seen == 16'h0000 |=> $stable(counter_o);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved");
    property p_count_step;
        quiet && reload_seen != 16'h0000 && counter_o < reload_seen
            |=> counter_o == $past(counter_o) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter step wrong");
    property p_wrap;
        quiet && reload_seen != 16'h0000 && counter_o == reload_seen
            |=> counter_o == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");
    property p_update_wrap;
        update_o && quiet && reload_seen != 16'h0000
            |=> counter_o == 16'h0000 && !update_o;
    endproperty
    a_update_wrap: assert property (p_update_wrap)
        else $error("update away from wrap");
    property p_hole_zero;
        wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we &&
            wb_req_i.adr == hole_offset && !wb_ack_o |=> wb_dat_o == 32'h0;
    endproperty
    a_hole_zero: assert property (p_hole_zero) else $error("hole read");

    c_update: cover property (update_o);
    c_driving: cover property (pins_oe_o != 4'h0);
    c_capture: cover property (capture_i != 4'h0);
endmodule // adv_timer_monitor

// ==== verif/test_adv_timer_reload_compare_deadtime.sv ====
// Self-checking bench for the reload, compare and lock section.
// Assumes the package, the design and the monitor are compiled first.
`timescale 1ns/10ps
module test_adv_timer_reload_compare_deadtime;
    import adv_timer_pkg::*;
    localparam int limit = 5000;        // Bound on every wait
    logic               clk_i;
    logic               rst_i;
    wb_req_type         wb_req_i;
    logic [31:0]        wb_dat_o;
    logic               wb_ack_o;
    logic               dt_tick_i;
    logic [3:0]         capture_i;
    logic [15:0]        counter_o;
    logic               update_o;
    pin_pair_type [3:0] pins_o;
    logic [3:0]         pins_oe_o;
    int                 failures;
    int                 comparisons;
    logic [31:0]        rd;             // Data of the last bus answer

    adv_timer_reload_compare_deadtime DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .dt_tick_i(dt_tick_i), .capture_i(capture_i), .counter_o(counter_o),
        .update_o(update_o), .pins_o(pins_o), .pins_oe_o(pins_oe_o));

    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic stop_test;
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // A used-up wait counts as a failure and ends the run
    task automatic guard(input int k);
        if (k >= limit) begin
            failures++;
            stop_test();
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf,
                      dat: d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < limit);
        rd = wb_dat_o;
        wb_req_i.cyc <= 1'b0;
        wb_req_i.stb <= 1'b0;
        guard(k);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    task automatic wait_cnt(input logic [15:0] v);
        int k;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (counter_o !== v && k < limit);
        guard(k);
    endtask

    // Cycles from here to the next update pulse
    task automatic interval(output int k);
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (update_o !== 1'b1 && k < limit);
        guard(k);
    endtask

    task automatic t_reset_values;
        logic [7:0] offs [7];
        offs = '{reload_offset, repetition_offset, channel1_offset,
                 channel2_offset, channel3_offset, channel4_offset,
                 brake_offset};
        foreach (offs[i]) begin
            rd_chk("reset value", offs[i], i == 0 ? 32'hffff : 32'h0);
        end
        bus(1'b1, 8'h60, 32'h1234);
        rd_chk("unmapped", 8'h60, 32'h0);
    endtask

    task automatic t_reload_zero;
        logic [15:0] held;
        bus(1'b1, reload_offset, 32'h0);
        repeat (3) @(negedge clk_i);
        held = counter_o;
        repeat (20) @(negedge clk_i);
        check("stopped counter", {16'h0, counter_o}, {16'h0, held});
    endtask

    task automatic t_repetition;
        int k;
        do_reset();
        bus(1'b1, reload_offset, 32'h4);
        bus(1'b1, repetition_offset, 32'h2);
        interval(k);
        interval(k);
        check("interval rep 2", k, 15);
        bus(1'b1, repetition_offset, 32'h0);
        interval(k);
        check("old count kept", k > 5, 1);
        interval(k);
        check("interval rep 0", k, 5);
    endtask

    task automatic t_channels;
        logic [15:0] st [4];
        int k;
        st = '{16'h0000, 16'h0400, 16'h8000, 16'h8800};
        bus(1'b1, reload_offset, 32'h9);
        foreach (st[i]) begin
            bus(1'b1, output_ctrl_offset, 32'h0);
            bus(1'b1, brake_offset, {16'h0, st[i]});
            bus(1'b1, output_ctrl_offset, 32'h1111);
            repeat (4) @(negedge clk_i);
            check("drive enable", pins_oe_o, st[i][10] | st[i][11] ?
                  32'hf : 32'h0);
        end
        bus(1'b1, repetition_offset, 32'd200);
        interval(k);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, channel1_offset + 8'(4 * i), 32'h5);
            wait_cnt(16'h1);
            check("pin below", pins_o[i].main_pin, 1'b1);
            wait_cnt(16'h8);
            check("pin above", pins_o[i].main_pin, 1'b0);
        end
        bus(1'b1, channel_ctrl_offset, 32'h2);
        bus(1'b1, channel1_offset, 32'h0);
        wait_cnt(16'h1);
        check("buffered", pins_o[0].main_pin, 1'b1);
        interval(k);
        wait_cnt(16'h1);
        check("applied", pins_o[0].main_pin, 1'b0);
    endtask

    task automatic t_capture;
        logic [15:0] seen;
        bus(1'b1, channel_ctrl_offset, 32'h10);
        @(posedge clk_i);
        capture_i <= 4'h2;
        @(negedge clk_i);
        seen = counter_o;
        @(posedge clk_i);
        capture_i <= 4'h0;
        rd_chk("captured", channel2_offset, {16'h0, seen});
    endtask

    task automatic t_lock;
        logic [31:0] lv;
        for (int i = 0; i < 4; i++) begin
            lv = 32'(i);
            do_reset();
            bus(1'b1, channel_ctrl_offset, 32'he);
            bus(1'b1, brake_offset, 32'h7c25 | (lv << 8));
            bus(1'b1, brake_offset, 32'h8000);
            bus(1'b1, channel_ctrl_offset, 32'h0);
            rd_chk("brake", brake_offset, 32'h8000 | (lv << 8) |
                   (i > 0 ? 32'h7025 : 32'h0) | (i > 1 ? 32'h0c00 : 32'h0));
            rd_chk("mode", channel_ctrl_offset, i == 3 ? 32'he : 32'h0);
        end
    endtask

    // Idle off-state on: dead-time gap per encoding range, then idle level
    task automatic t_deadtime;
        logic [7:0] deadtime_setting [4];
        int         len [4];
        int         k;
        int         j;
        deadtime_setting = '{8'h05, 8'h85, 8'hc3, 8'he1};
        len = '{5, 138, 280, 528};
        do_reset();
        foreach (deadtime_setting[i]) begin
            bus(1'b1, output_ctrl_offset, 32'h0);
            bus(1'b1, brake_offset, {24'h000004, deadtime_setting[i]});
            bus(1'b1, output_ctrl_offset, 32'h0001_0009);
            k = 0;
            j = 0;
            do begin
                @(negedge clk_i);
                j++;
                if (pins_oe_o[0] && !pins_o[0].main_pin) k++;
            end while (!(pins_oe_o[0] && pins_o[0].main_pin) && j < limit);
            guard(j);
            check("dead time", k, len[i]);
            check("idle level", pins_o[0], 32'h3);
        end
    endtask

    // Main sequence
    initial begin
        failures = 0;
        comparisons = 0;
        rst_i = 1'b1;
        wb_req_i = '0;
        dt_tick_i = 1'b1;
        capture_i = 4'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
        t_reload_zero();
        t_repetition();
        t_channels();
        t_capture();
        t_deadtime();
        t_lock();
        stop_test();
    end
endmodule // test_adv_timer_reload_compare_deadtime

bind adv_timer_reload_compare_deadtime adv_timer_monitor MON (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dt_tick_i(dt_tick_i), .capture_i(capture_i),
    .counter_o(counter_o), .update_o(update_o), .pins_o(pins_o),
    .pins_oe_o(pins_oe_o));
